/* File: rtl/eqr_classify.sv */
`timescale 1ns/1ps
module eqr_classify (
  // Lexer findings
  input wire logic tok_valid,
  input wire logic tok_bad_char,
  input wire logic tok_blank_sep,
  input wire logic tok_no_at,
  input wire logic tok_bad_sep,
  // Header and parameter counts
  input wire logic hdr_done,
  input wire logic [7:0] hdr_len,
  input wire logic cmd_end,
  input wire logic [3:0] param_count,
  input wire logic [3:0] param_min,
  input wire logic [3:0] param_max,
  // Bus trigger message
  input wire logic get_msg,
  input wire logic in_command,
  // Errors from other units
  input wire logic ext_valid,
  input wire eqr_pkg::eqr_code_type ext_code,
  // Result
  eqr_err_if.src err
);
  import eqr_pkg::*;

  // One error per cycle; parser findings outrank other units
  always_comb begin
    err.valid = 1'b1;
    err.code = EQR_C_NONE;
    if (get_msg && in_command) begin
      err.code = EQR_C_GET;
    end else if (tok_valid && tok_bad_char) begin
      err.code = EQR_C_BADCHAR;
    end else if (tok_valid && (tok_blank_sep || tok_no_at)) begin
      err.code = EQR_C_SYNTAX;
    end else if (tok_valid && tok_bad_sep) begin
      err.code = EQR_C_SEP;
    end else if (hdr_done && hdr_len > EQR_HDR_MAX) begin
      err.code = EQR_C_LONGHDR;
    end else if (cmd_end && param_count > param_max) begin
      err.code = EQR_C_XPARAM;
    end else if (cmd_end && param_count < param_min) begin
      err.code = EQR_C_MPARAM;
    end else if (ext_valid) begin
      err.code = ext_code;
    end else begin
      err.valid = 1'b0;
    end
  end
endmodule

/* File: rtl/eqr_if.sv */
`timescale 1ns/1ps
// New error from the classifier to the queue
interface eqr_err_if;
  logic valid;
  eqr_pkg::eqr_code_type code;
  modport src(output valid, output code);
  modport dst(input valid, input code);
endinterface

// Message text lookup
interface eqr_msg_if;
  eqr_pkg::eqr_code_type code;
  logic [6:0] idx;
  logic [7:0] chr;
  logic [6:0] len;
  modport req(output code, output idx, input chr, input len);
  modport rom(input code, input idx, output chr, output len);
endinterface

/* File: rtl/eqr_msg_rom.sv */
`timescale 1ns/1ps
module eqr_msg_rom (
  // Lookup port
  eqr_msg_if.rom m
);
  import eqr_pkg::*;

  logic [EQR_STR_W-1:0] str;

  // Text chosen by code at readout time; slots hold only codes
  always_comb begin
    int pos;
    pos = 0;
    str = EQR_STR_W'("Undefined error code");
    m.len = 7'd20;
    unique case (m.code)
      EQR_C_NONE: begin
        str = EQR_STR_W'("No error");
        m.len = 7'd8;
      end
      EQR_C_BADCHAR: begin
        str = EQR_STR_W'("Invalid character");
        m.len = 7'd17;
      end
      EQR_C_SYNTAX: begin
        str = EQR_STR_W'("Syntax error");
        m.len = 7'd12;
      end
      EQR_C_SEP: begin
        str = EQR_STR_W'("Invalid separator");
        m.len = 7'd17;
      end
      EQR_C_GET: begin
        str = EQR_STR_W'("GET not allowed");
        m.len = 7'd15;
      end
      EQR_C_XPARAM: begin
        str = EQR_STR_W'("Parameter not allowed");
        m.len = 7'd21;
      end
      EQR_C_MPARAM: begin
        str = EQR_STR_W'("Missing parameter");
        m.len = 7'd17;
      end
      EQR_C_LONGHDR: begin
        str = EQR_STR_W'("Program mnemonic too long");
        m.len = 7'd25;
      end
      EQR_C_OVF: begin
        str = EQR_STR_W'("Error queue overflow");
        m.len = 7'd20;
      end
      default: begin
      end
    endcase
    // First character sits in the top byte of the used part
    pos = (int'(m.len) - 1 - int'(m.idx)) * 8;
    m.chr = (m.idx < m.len && pos >= 0) ? str[pos +: 8] : EQR_CH_BLANK;
  end
endmodule

/* File: rtl/eqr_pkg.sv */
package eqr_pkg;
  // Queue depth per product configuration
  localparam int EQR_DEPTH_STD = 10;
  localparam int EQR_DEPTH_EXT = 20;
  // Longest message text and header keyword
  localparam logic [6:0] EQR_MSG_MAX = 7'h50;
  localparam logic [7:0] EQR_HDR_MAX = 8'h0c;
  localparam int EQR_STR_W = 8 * 80;

  typedef logic signed [15:0] eqr_code_type;

  // Error codes
  localparam eqr_code_type EQR_C_NONE = 16'sh0000;
  localparam eqr_code_type EQR_C_BADCHAR = -16'sh0065;
  localparam eqr_code_type EQR_C_SYNTAX = -16'sh0066;
  localparam eqr_code_type EQR_C_SEP = -16'sh0067;
  localparam eqr_code_type EQR_C_GET = -16'sh0069;
  localparam eqr_code_type EQR_C_XPARAM = -16'sh006c;
  localparam eqr_code_type EQR_C_MPARAM = -16'sh006d;
  localparam eqr_code_type EQR_C_LONGHDR = -16'sh0070;
  localparam eqr_code_type EQR_C_OVF = -16'sh015e;

  // Characters of the reply
  localparam logic [7:0] EQR_CH_MINUS = 8'h2d;
  localparam logic [7:0] EQR_CH_PLUS = 8'h2b;
  localparam logic [7:0] EQR_CH_ZERO = 8'h30;
  localparam logic [7:0] EQR_CH_COMMA = 8'h2c;
  localparam logic [7:0] EQR_CH_QUOTE = 8'h22;
  localparam logic [7:0] EQR_CH_BLANK = 8'h20;

  // Reply formatter steps
  typedef enum logic [3:0] {
    EQR_IDLE = 4'h0,
    EQR_SIGN = 4'h1,
    EQR_D2 = 4'h2,
    EQR_D1 = 4'h3,
    EQR_D0 = 4'h4,
    EQR_COMMA = 4'h5,
    EQR_QOPEN = 4'h6,
    EQR_TEXT = 4'h7,
    EQR_DRAIN = 4'h8
  } eqr_fmt_type;
endpackage

/* File: rtl/eqr_top.sv */
`timescale 1ns/1ps
// Function
// - Stored errors come back oldest first.
// - Each remote query returns one entry and removes it in the same read.
// - Error indicator lit while entries remain, off once the last is read.
// - Beeper pulses once for every new error.
// - Depth 10 or 20; on overflow newest slot becomes the overflow marker.
// - After overflow further errors are dropped until one entry is removed.
// - Query on an empty queue answers no-error.
// - Clear-status command and power cycle empty the queue.
// - Factory reset and instrument preset leave the queue untouched.
// - Leaving the front-panel error menu empties the whole queue.
// - Reply is signed code, comma, quoted text of at most 80 characters.
// - Disallowed character in header or parameter gives -101.
// - Blank beside header colon or before comma, or missing @, gives -102.
// - Comma for colon, semicolon or blank, or blank for comma, gives -103.
// - Group execute trigger inside a command string gives -105.
// - Too many parameters gives -108.
// - Too few parameters gives -109.
// - Header keyword over 12 characters gives -112.
module eqr_top #(
  parameter int DEPTH = eqr_pkg::EQR_DEPTH_STD
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Lexer findings
  input wire logic tok_valid,
  input wire logic tok_bad_char,
  input wire logic tok_blank_sep,
  input wire logic tok_no_at,
  input wire logic tok_bad_sep,
  // Header and parameter counts
  input wire logic hdr_done,
  input wire logic [7:0] hdr_len,
  input wire logic cmd_end,
  input wire logic [3:0] param_count,
  input wire logic [3:0] param_min,
  input wire logic [3:0] param_max,
  // Bus trigger message
  input wire logic get_msg,
  input wire logic in_command,
  // Errors from other units
  input wire logic ext_valid,
  input wire eqr_pkg::eqr_code_type ext_code,
  // Clearing commands
  input wire logic cls_cmd,
  input wire logic view_exit,
  // Front-panel viewer
  input wire logic [$clog2(DEPTH+1)-1:0] view_sel,
  output logic [15:0] view_code,
  // Remote query and reply stream
  input wire logic query_req,
  input wire logic char_ready,
  output logic char_valid,
  output logic [7:0] char_data,
  output logic char_last,
  output logic query_busy,
  // Indicators
  output logic err_led,
  output logic beep
);
  import eqr_pkg::*;

  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);

  eqr_err_if err_bus();
  eqr_msg_if msg_bus();

  eqr_classify u_classify (
    .tok_valid, .tok_bad_char, .tok_blank_sep, .tok_no_at, .tok_bad_sep, .hdr_done, .hdr_len, .cmd_end,
    .param_count, .param_min, .param_max, .get_msg, .in_command, .ext_valid, .ext_code, .err(err_bus.src)
  );

  eqr_msg_rom u_msg_rom (.m(msg_bus.rom));

  //////////////////////////////////////////////////////////////////////////////
  // Queue storage
  eqr_code_type mem_q [DEPTH];
  logic [PW-1:0] rd_q, rd_d, wr_addr;
  logic [CW-1:0] cnt_q, cnt_d;
  logic ovf_q, ovf_d, led_q, led_d, beep_q, beep_d, wr_en, pop, clr;
  eqr_code_type view_q, view_d, wr_code, head_code, take_code;
  eqr_fmt_type fmt_q, fmt_d;

  // Circular index; avoids a power-of-two depth
  function automatic logic [PW-1:0] wrap(input logic [PW-1:0] b, input logic [CW-1:0] o);
    wrap = PW'((int'(b) + int'(o)) % DEPTH);
  endfunction

  // Query is taken only between replies
  assign pop = query_req && fmt_q == EQR_IDLE;
  // Reset and preset commands are deliberately not clear sources
  assign clr = cls_cmd || view_exit;
  assign head_code = mem_q[rd_q];
  assign take_code = (cnt_q == '0) ? EQR_C_NONE : head_code;

  // Clear or pop first, then the new error, so an error in the same cycle as a clear or pop is kept
  always_comb begin
    rd_d = rd_q;
    cnt_d = cnt_q;
    ovf_d = ovf_q;
    wr_en = 1'b0;
    wr_addr = rd_q;
    wr_code = err_bus.code;
    if (clr) begin
      rd_d = '0;
      cnt_d = '0;
      ovf_d = 1'b0;
    end else if (pop && cnt_q != '0) begin
      rd_d = wrap(rd_q, CW'(1));
      cnt_d = cnt_q - CW'(1);
      ovf_d = 1'b0;
    end
    if (err_bus.valid && !ovf_d) begin
      wr_en = 1'b1;
      if (cnt_d < FULL) begin
        wr_addr = wrap(rd_d, cnt_d);
        cnt_d = cnt_d + CW'(1);
      end else begin
        wr_addr = wrap(rd_d, cnt_d - CW'(1));
        wr_code = EQR_C_OVF;
        ovf_d = 1'b1;
      end
    end
    led_d = cnt_d != '0;
    beep_d = err_bus.valid;
    view_d = (view_sel < cnt_q) ? mem_q[wrap(rd_q, view_sel)] : EQR_C_NONE;
  end

  // Queue registers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rd_q <= '0;
      cnt_q <= '0;
      ovf_q <= 1'b0;
      led_q <= 1'b0;
      beep_q <= 1'b0;
      view_q <= EQR_C_NONE;
    end else begin
      rd_q <= rd_d;
      cnt_q <= cnt_d;
      ovf_q <= ovf_d;
      led_q <= led_d;
      beep_q <= beep_d;
      view_q <= view_d;
    end
  end

  // Slot contents need no reset; the count guards stale slots
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem_q[wr_addr] <= wr_code;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Reply formatter
  eqr_code_type code_q, code_d;
  logic [6:0] idx_q, idx_d;
  logic cv_q, cv_d, cl_q, cl_d, busy_q, busy_d, adv;
  logic [7:0] cd_q, cd_d;
  logic [15:0] mag;
  logic [3:0] d2, d1, d0;

  assign msg_bus.code = code_q;
  assign msg_bus.idx = idx_q;
  assign mag = (code_q < 0) ? 16'(-code_q) : 16'(code_q);
  assign d2 = 4'((mag / 16'd100) % 16'd10);
  assign d1 = 4'((mag / 16'd10) % 16'd10);
  assign d0 = 4'(mag % 16'd10);
  // A new character may be loaded when the slot is free or being taken
  assign adv = !cv_q || char_ready;

  // One character per step, leading zeros suppressed
  always_comb begin
    fmt_d = fmt_q;
    code_d = code_q;
    idx_d = idx_q;
    cv_d = cv_q && !char_ready;
    cd_d = cd_q;
    cl_d = cl_q && !char_ready;
    busy_d = busy_q;
    unique case (fmt_q)
      EQR_IDLE: begin
        if (pop) begin
          code_d = take_code;
          busy_d = 1'b1;
          fmt_d = EQR_SIGN;
        end
      end
      EQR_SIGN: begin
        if (adv) begin
          cv_d = 1'b1;
          cd_d = (code_q < 0) ? EQR_CH_MINUS : EQR_CH_PLUS;
          fmt_d = EQR_D2;
        end
      end
      EQR_D2: begin
        if (adv) begin
          cv_d = d2 != 4'h0;
          cd_d = EQR_CH_ZERO + 8'(d2);
          fmt_d = EQR_D1;
        end
      end
      EQR_D1: begin
        if (adv) begin
          cv_d = d2 != 4'h0 || d1 != 4'h0;
          cd_d = EQR_CH_ZERO + 8'(d1);
          fmt_d = EQR_D0;
        end
      end
      EQR_D0: begin
        if (adv) begin
          cv_d = 1'b1;
          cd_d = EQR_CH_ZERO + 8'(d0);
          fmt_d = EQR_COMMA;
        end
      end
      EQR_COMMA: begin
        if (adv) begin
          cv_d = 1'b1;
          cd_d = EQR_CH_COMMA;
          fmt_d = EQR_QOPEN;
        end
      end
      EQR_QOPEN: begin
        if (adv) begin
          cv_d = 1'b1;
          cd_d = EQR_CH_QUOTE;
          idx_d = '0;
          fmt_d = EQR_TEXT;
        end
      end
      EQR_TEXT: begin
        if (adv) begin
          cv_d = 1'b1;
          if (idx_q < msg_bus.len && idx_q < EQR_MSG_MAX) begin
            cd_d = msg_bus.chr;
            idx_d = idx_q + 7'd1;
          end else begin
            cd_d = EQR_CH_QUOTE;
            cl_d = 1'b1;
            fmt_d = EQR_DRAIN;
          end
        end
      end
      EQR_DRAIN: begin
        if (adv) begin
          busy_d = 1'b0;
          fmt_d = EQR_IDLE;
        end
      end
      default: begin
        fmt_d = EQR_IDLE;
        busy_d = 1'b0;
      end
    endcase
  end

  // Formatter registers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      fmt_q <= EQR_IDLE;
      code_q <= EQR_C_NONE;
      idx_q <= '0;
      cv_q <= 1'b0;
      cd_q <= '0;
      cl_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      fmt_q <= fmt_d;
      code_q <= code_d;
      idx_q <= idx_d;
      cv_q <= cv_d;
      cd_q <= cd_d;
      cl_q <= cl_d;
      busy_q <= busy_d;
    end
  end

  // Outputs straight from flops
  assign view_code = view_q;
  assign char_valid = cv_q;
  assign char_data = cd_q;
  assign char_last = cl_q;
  assign query_busy = busy_q;
  assign err_led = led_q;
  assign beep = beep_q;

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_take;
    pop && cnt_q != '0;
  endsequence
  sequence s_sign_step;
    fmt_q == EQR_SIGN && adv;
  endsequence

  AST_OLDEST_FIRST: assert property (s_take |=> code_q == $past(head_code))
    else $error("reply code is not the oldest entry");
  AST_ONE_REMOVED: assert property (s_take and !clr and !err_bus.valid |=> cnt_q == $past(cnt_q) - CW'(1))
    else $error("query did not remove exactly one entry");
  AST_LED_OFF: assert property (s_take and cnt_q == CW'(1) and !clr and !err_bus.valid
    |=> !err_led ##1 (err_led == $past(err_bus.valid)))
    else $error("indicator still on after last entry read");
  AST_LED_TRACK: assert property ($changed(err_led) |-> $past(err_bus.valid || clr || pop))
    else $error("indicator changed with no error, clear or query");
  AST_BEEP: assert property (err_bus.valid |=> beep ##1 (beep == $past(err_bus.valid)))
    else $error("beeper did not follow new error");
  AST_OVERFLOW: assert property (err_bus.valid && !ovf_q && cnt_q == FULL && !pop && !clr
    |=> ovf_q && cnt_q == FULL && mem_q[wrap(rd_q, FULL - CW'(1))] == EQR_C_OVF)
    else $error("overflow marker not placed in newest slot");
  AST_DISCARD: assert property (ovf_q && !pop && !clr |=> $stable(cnt_q) && ovf_q)
    else $error("error stored while overflowed");
  AST_EMPTY_REPLY: assert property (pop && cnt_q == '0 |=> code_q == EQR_C_NONE)
    else $error("empty query did not give no-error");
  AST_CLEAR: assert property (clr && !err_bus.valid |=> cnt_q == '0 && !ovf_q && !err_led)
    else $error("clear left entries behind");
  AST_SIGN_FIRST: assert property (s_sign_step |=> char_valid &&
    (char_data == EQR_CH_MINUS || char_data == EQR_CH_PLUS))
    else $error("reply does not open with a sign");
  AST_CLOSE_QUOTE: assert property (char_last |-> char_valid && char_data == EQR_CH_QUOTE && idx_q <= EQR_MSG_MAX)
    else $error("reply not closed by quote within length");
  AST_GET_CODE: assert property (get_msg && in_command |-> err_bus.valid && err_bus.code == EQR_C_GET)
    else $error("trigger inside command not coded");
  AST_BADCHAR: assert property (tok_valid && tok_bad_char && !(get_msg && in_command)
    |-> err_bus.code == EQR_C_BADCHAR ##1 beep)
    else $error("invalid character not coded");
  AST_LONG_HDR: assert property (hdr_done && hdr_len == 8'h0d && !get_msg && !tok_valid
    |-> err_bus.code == EQR_C_LONGHDR)
    else $error("13 character keyword not coded");
endmodule

/* File: testbench/eqr_sink.sv */
`timescale 1ns/1ps
// Host side of the reply stream: collects characters, may pace slowly
module eqr_sink (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Reply stream
  input wire logic char_valid,
  input wire logic [7:0] char_data,
  input wire logic char_last,
  output logic char_ready,
  // Pacing from the bench
  input wire logic stall
);
  string reply;
  int n_done;

  initial begin
    char_ready = 1'b0;
    reply = "";
    n_done = 0;
  end

  // Ready drops every other cycle when stalling, so each char must be held
  always @(posedge clk) begin
    if (char_valid && char_ready && !reset) begin
      reply = $sformatf("%s%c", reply, char_data);
      if (char_last) begin
        n_done++;
      end
    end
    #1;
    char_ready = reset ? 1'b0 : (stall ? ~char_ready : 1'b1);
  end
endmodule

/* File: testbench/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  import eqr_pkg::*;
  localparam int DEPTH = EQR_DEPTH_STD;
  localparam int CW = $clog2(DEPTH+1);
  logic clk, reset, tok_valid, tok_bad_char, tok_blank_sep, tok_no_at, tok_bad_sep;
  logic hdr_done, cmd_end, get_msg, in_command, ext_valid, cls_cmd, view_exit, query_req, stall;
  logic [7:0] hdr_len, char_data;
  logic [3:0] param_count, param_min, param_max;
  eqr_code_type ext_code;
  logic [CW-1:0] view_sel;
  logic [15:0] view_code;
  logic char_ready, char_valid, char_last, query_busy, err_led, beep;
  int n_mismatch, n_compared;
  eqr_code_type exp_tab [8] = '{EQR_C_BADCHAR, EQR_C_SYNTAX, EQR_C_SYNTAX, EQR_C_SEP,
                                EQR_C_GET, EQR_C_LONGHDR, EQR_C_XPARAM, EQR_C_MPARAM};

  eqr_top #(.DEPTH(DEPTH)) u_dut (
    .clk, .reset, .tok_valid, .tok_bad_char, .tok_blank_sep, .tok_no_at, .tok_bad_sep,
    .hdr_done, .hdr_len, .cmd_end, .param_count, .param_min, .param_max, .get_msg,
    .in_command, .ext_valid, .ext_code, .cls_cmd, .view_exit, .view_sel, .view_code,
    .query_req, .char_ready, .char_valid, .char_data, .char_last, .query_busy,
    .err_led, .beep
  );
  eqr_sink u_sink (.clk, .reset, .char_valid, .char_data, .char_last, .char_ready, .stall);

  // Free-running 125 MHz clock
  initial clk = 1'b0;
  always #4 clk = ~clk;

  ////////////////////////////////////////////////////////////
  // Drive just after the edge so sampling never races
  task automatic cyc(int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic print_verdict();
    $display("Mismatches %0d, comparisons %0d", n_mismatch, n_compared);
    if (n_mismatch == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Codes and flags
  task automatic chk(logic [15:0] got, logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Whole replies, packed into vectors for a hex report
  task automatic chk_s(string got, string exp);
    logic [255:0] g, e;
    g = '0;
    e = '0;
    foreach (got[i]) g = {g[247:0], got[i]};
    foreach (exp[i]) e = {e[247:0], exp[i]};
    n_compared++;
    if (got != exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  function automatic logic [15:0] rc(string s);
    int v;
    v = 0;
    void'($sscanf(s, "%d", v));
    return 16'(v);
  endfunction

  // One error source per kind; kinds 8 to 10 sit just inside the legal side
  task automatic fire(int k, logic exp_beep);
    tok_valid = k < 4;
    tok_bad_char = k == 0;
    tok_blank_sep = k == 1;
    tok_no_at = k == 2;
    tok_bad_sep = k == 3;
    get_msg = k == 4 || k == 8;
    in_command = k == 4;
    hdr_done = k == 5 || k == 9;
    hdr_len = (k == 5) ? 8'h0d : 8'h0c;
    cmd_end = k == 6 || k == 7 || k == 10;
    param_count = (k == 6) ? 4'h3 : (k == 7) ? 4'h0 : 4'h2;
    ext_valid = k == 11;
    cyc();
    {tok_valid, get_msg, hdr_done, cmd_end, ext_valid} = '0;
    chk(beep, exp_beep);
    cyc();
    chk(beep, 1'b0);
  endtask

  // Remote query; a lost reply ends the run
  task automatic query(output string s);
    int i;
    u_sink.reply = "";
    i = u_sink.n_done;
    query_req = 1'b1;
    cyc();
    query_req = 1'b0;
    for (int t = 0; t < 600 && u_sink.n_done == i; t++) cyc();
    for (int t = 0; t < 10 && query_busy !== 1'b0; t++) cyc();
    if (u_sink.n_done == i || query_busy !== 1'b0) begin
      n_mismatch++;
      print_verdict();
    end
    s = u_sink.reply;
  endtask

  // Viewer output lags the select by one cycle
  task automatic peek(int sel, eqr_code_type exp);
    view_sel = CW'(sel);
    cyc(2);
    chk(view_code, exp);
  endtask

  ////////////////////////////////////////////////////////////
  task automatic t_reset();
    string s;
    chk(err_led, 1'b0);
    chk(char_valid, 1'b0);
    query(s);
    chk_s(s, "+0,\"No error\"");
  endtask

  task automatic t_codes();
    string s;
    for (int k = 0; k < 11; k++) fire(k, k < 8);
    chk(err_led, 1'b1);
    peek(7, exp_tab[7]);
    stall = 1'b1;
    query(s);
    chk_s(s, "-101,\"Invalid character\"");
    stall = 1'b0;
    for (int k = 1; k < 8; k++) begin
      query(s);
      chk(rc(s), exp_tab[k]);
      chk(16'(s[s.len()-1]), 16'(EQR_CH_QUOTE));
    end
    chk(err_led, 1'b0);
    query(s);
    chk_s(s, "+0,\"No error\"");
  endtask

  // Overfill, then show one removal reopens the queue
  task automatic t_overflow();
    string s;
    for (int i = 1; i <= DEPTH + 2; i++) begin
      ext_code = eqr_code_type'(i);
      fire(11, 1'b1);
    end
    peek(DEPTH - 2, eqr_code_type'(DEPTH - 1));
    peek(DEPTH - 1, EQR_C_OVF);
    peek(DEPTH, EQR_C_NONE);
    query(s);
    chk(rc(s), 16'h0001);
    peek(DEPTH - 2, EQR_C_OVF);
    ext_code = 16'sh004d;
    fire(11, 1'b1);
    peek(DEPTH - 1, 16'sh004d);
    cls_cmd = 1'b1;
    cyc();
    cls_cmd = 1'b0;
    cyc();
    chk(err_led, 1'b0);
    peek(0, EQR_C_NONE);
  endtask

  task automatic t_clear();
    string s;
    fire(0, 1'b1);
    fire(3, 1'b1);
    view_exit = 1'b1;
    cyc();
    view_exit = 1'b0;
    cyc();
    chk(err_led, 1'b0);
    peek(1, EQR_C_NONE);
    fire(4, 1'b1);
    reset = 1'b1;
    cyc(2);
    reset = 1'b0;
    cyc();
    chk(err_led, 1'b0);
    query(s);
    chk_s(s, "+0,\"No error\"");
  endtask

  ////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {tok_valid, tok_bad_char, tok_blank_sep, tok_no_at, tok_bad_sep} = '0;
    {hdr_done, cmd_end, get_msg, in_command, ext_valid, cls_cmd, view_exit} = '0;
    {query_req, stall, hdr_len, param_count, view_sel} = '0;
    param_min = 4'h1;
    param_max = 4'h2;
    ext_code = 16'sh0000;
    n_mismatch = 0;
    n_compared = 0;
    reset = 1'b1;
    cyc(8);
    reset = 1'b0;
    cyc();
    t_reset();
    t_codes();
    t_overflow();
    t_clear();
    print_verdict();
  end
endmodule
